// *** frac_pkg.sv ***
`default_nettype none

package frac_pkg;

    // ****************************************************************
    // Field widths
    // ****************************************************************
    localparam int INC_W = 4;
    localparam int MOD_W = 5;
    localparam int SUM_W = 6;

    // ****************************************************************
    // Values after reset and the smallest modulus
    // ****************************************************************
    localparam logic [INC_W-1:0] NUM_RESET    = 4'h0;
    localparam logic [INC_W-1:0] INC_RESET    = 4'h0;
    localparam logic [MOD_W-1:0] MOD_RESET    = 5'h01;
    localparam logic [MOD_W-1:0] MOD_MIN      = 5'h01;

    // ****************************************************************
    // Compensation pulse length in reference clock cycles
    // ****************************************************************
    localparam int COMP_LEN_W = 4;
    localparam logic [COMP_LEN_W-1:0] COMP_LEN       = 4'h8;
    localparam logic [COMP_LEN_W-1:0] COMP_LEAD      = 4'h4;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_LEAD,
        PH_TRAIL
    } comp_state_type;

endpackage : frac_pkg

`default_nettype wire

// *** frac_comp_pulse.sv ***
`timescale 1ns/10ps
`default_nettype none

// ********************************************************************
// Compensation pulse timer
// ********************************************************************
module frac_comp_pulse
    import frac_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  early,
    input  wire logic [INC_W-1:0]      level,
    output logic                       active,
    output logic [INC_W-1:0]           amplitude
);

    comp_state_type           state_reg;
    comp_state_type           state_next;
    logic [COMP_LEN_W-1:0]    count_reg;
    logic [COMP_LEN_W-1:0]    count_next;
    logic [INC_W-1:0]         amp_reg;
    logic [INC_W-1:0]         amp_next;

    // Pulse opens COMP_LEAD cycles before the main pump edge and lasts
    // COMP_LEN, so it straddles the main pulse symmetrically
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        amp_next   = amp_reg;
        case (state_reg)
            PH_IDLE: begin
                if (early) begin
                    state_next = PH_LEAD;
                    count_next = COMP_LEN - 4'h1;
                    amp_next   = level;
                end
            end
            PH_LEAD, PH_TRAIL: begin
                if (count_reg == {COMP_LEN_W{1'b0}}) begin
                    state_next = PH_IDLE;
                    amp_next   = NUM_RESET;
                end else begin
                    count_next = count_reg - 4'h1;
                    if (count_reg == COMP_LEN - COMP_LEAD) begin
                        state_next = PH_TRAIL;
                    end
                end
            end
            default: begin
                state_next = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= PH_IDLE;
            count_reg <= 4'h0;
            amp_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            amp_reg   <= amp_next;
        end
    end

    assign active    = (state_reg != PH_IDLE);
    assign amplitude = amp_reg;

endmodule : frac_comp_pulse

`default_nettype wire

// *** fractional_n_accumulator.sv ***
`timescale 1ns/10ps
`default_nettype none

module fractional_n_accumulator
    import frac_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  TERMINAL_COUNT,
    input  wire logic                  PUMP_EARLY,
    input  wire logic [INC_W-1:0]      FRAC_INCREMENT,
    input  wire logic [MOD_W-1:0]      FRAC_MODULUS,
    output logic                       DIVIDE_N_PLUS_ONE,
    output logic [INC_W-1:0]           NUMERATOR,
    output logic [INC_W-1:0]           MAIN_RIPPLE_WIDTH,
    output logic                       COMP_PULSE_ACTIVE,
    output logic [INC_W-1:0]           COMP_PULSE_AMPLITUDE,
    output logic                       COMP_SUM_ENABLE
);

    // ****************************************************************
    // Step kinds
    // ****************************************************************
    typedef enum logic [1:0] {
        STEP_HOLD,
        STEP_CLEAR,
        STEP_ADD,
        STEP_WRAP
    } step_kind_type;

    // ****************************************************************
    // Accumulator state
    // ****************************************************************
    logic [INC_W-1:0]      num_reg;
    logic [INC_W-1:0]      num_next;
    logic                  plus_one_reg;
    logic                  plus_one_next;

    // ****************************************************************
    // Step arithmetic and control terms
    // ****************************************************************
    logic [MOD_W-1:0]      eff_modulus;
    logic [SUM_W-1:0]      step_sum;
    logic                  step_overflow;
    logic [INC_W-1:0]      step_wrapped;
    logic                  integer_mode;
    logic                  advance;
    step_kind_type         step_kind;

    // ****************************************************************
    // Compensation pump links
    // ****************************************************************
    logic                  comp_active;
    logic [INC_W-1:0]      comp_amplitude;

    // ****************************************************************
    // Modulus guard
    // ****************************************************************
    // A zero modulus would overflow on every step and leave the
    // numerator above the modulus, so it runs as a modulus of one
    function automatic logic [MOD_W-1:0] guard_modulus(
        input logic [MOD_W-1:0] modulus
    );
        if (modulus < MOD_MIN) begin
            guard_modulus = MOD_MIN;
        end else begin
            guard_modulus = modulus;
        end
    endfunction : guard_modulus

    // ****************************************************************
    // Numerator plus increment
    // ****************************************************************
    function automatic logic [SUM_W-1:0] frac_sum(
        input logic [INC_W-1:0] num,
        input logic [INC_W-1:0] inc
    );
        frac_sum = {2'b00, num} + {2'b00, inc};
    endfunction : frac_sum

    // ****************************************************************
    // Overflow test
    // ****************************************************************
    function automatic logic frac_overflow(
        input logic [SUM_W-1:0] sum,
        input logic [MOD_W-1:0] modulus
    );
        frac_overflow = (sum >= {1'b0, modulus});
    endfunction : frac_overflow

    // ****************************************************************
    // Wrapped numerator
    // ****************************************************************
    // An increment at or above the modulus is outside the contract;
    // the difference is then simply cut to the numerator width
    function automatic logic [INC_W-1:0] frac_wrap(
        input logic [SUM_W-1:0] sum,
        input logic [MOD_W-1:0] modulus
    );
        logic [SUM_W-1:0] diff;
        diff      = sum - {1'b0, modulus};
        frac_wrap = diff[INC_W-1:0];
    endfunction : frac_wrap

    // ****************************************************************
    // Step kind decode
    // ****************************************************************
    // Integer mode is tested before overflow, so a zero increment never reports
    // an overflow whatever modulus is programmed
    function automatic step_kind_type decode_step(
        input logic adv,
        input logic int_mode,
        input logic ovf
    );
        if (!adv) begin
            decode_step = STEP_HOLD;
        end else if (int_mode) begin
            decode_step = STEP_CLEAR;
        end else if (ovf) begin
            decode_step = STEP_WRAP;
        end else begin
            decode_step = STEP_ADD;
        end
    endfunction : decode_step

    // ****************************************************************
    // Control decode
    // ****************************************************************
    always_comb begin
        eff_modulus  = guard_modulus(FRAC_MODULUS);
        integer_mode = (FRAC_INCREMENT == INC_RESET);
        advance      = TERMINAL_COUNT;
    end

    // ****************************************************************
    // Step arithmetic
    // ****************************************************************
    always_comb begin
        step_sum      = frac_sum(num_reg, FRAC_INCREMENT);
        step_overflow = frac_overflow(step_sum, eff_modulus);
        step_wrapped  = frac_wrap(step_sum, eff_modulus);
        step_kind     = decode_step(advance, integer_mode, step_overflow);
    end

    // ****************************************************************
    // Accumulator, advanced once per divider terminal count
    // ****************************************************************
    always_comb begin
        num_next      = num_reg;
        plus_one_next = plus_one_reg;
        case (step_kind)
            STEP_HOLD: begin
                num_next      = num_reg;
                plus_one_next = plus_one_reg;
            end
            STEP_CLEAR: begin
                num_next      = NUM_RESET;
                plus_one_next = 1'b0;
            end
            STEP_ADD: begin
                num_next      = step_sum[INC_W-1:0];
                plus_one_next = 1'b0;
            end
            STEP_WRAP: begin
                num_next      = step_wrapped;
                plus_one_next = 1'b1;
            end
            default: begin
                num_next      = num_reg;
                plus_one_next = plus_one_reg;
            end
        endcase
    end

    // ****************************************************************
    // Accumulator registers
    // ****************************************************************
    // Only the terminal count moves these, so the ratio seen by the
    // divider stays put for a whole divider cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            num_reg      <= NUM_RESET;
            plus_one_reg <= 1'b0;
        end else begin
            num_reg      <= num_next;
            plus_one_reg <= plus_one_next;
        end
    end

    // ****************************************************************
    // Divider and pump outputs
    // ****************************************************************
    assign DIVIDE_N_PLUS_ONE    = plus_one_reg;
    assign NUMERATOR            = num_reg;
    assign MAIN_RIPPLE_WIDTH    = num_reg;
    assign COMP_PULSE_ACTIVE    = comp_active;
    assign COMP_PULSE_AMPLITUDE = comp_amplitude;
    assign COMP_SUM_ENABLE      = comp_active;

    // ****************************************************************
    // Compensation pulse
    // ****************************************************************
    // The timer captures the numerator as it stands at the early
    // strobe, the value that sets the width of the coming main pulse
    frac_comp_pulse i_frac_comp_pulse (
        .clk       (CLK),
        .rst       (RST),
        .early     (PUMP_EARLY),
        .level     (num_reg),
        .active    (comp_active),
        .amplitude (comp_amplitude)
    );

endmodule : fractional_n_accumulator

`default_nettype wire

// *** frac_acc_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module frac_acc_checker
    import frac_pkg::*;
(
    input wire logic             CLK,
    input wire logic             RST,
    input wire logic             TERMINAL_COUNT,
    input wire logic             PUMP_EARLY,
    input wire logic [INC_W-1:0] FRAC_INCREMENT,
    input wire logic [MOD_W-1:0] FRAC_MODULUS,
    input wire logic             DIVIDE_N_PLUS_ONE,
    input wire logic [INC_W-1:0] NUMERATOR,
    input wire logic [INC_W-1:0] MAIN_RIPPLE_WIDTH,
    input wire logic             COMP_PULSE_ACTIVE,
    input wire logic [INC_W-1:0] COMP_PULSE_AMPLITUDE,
    input wire logic             COMP_SUM_ENABLE
);
    logic [SUM_W-1:0] sum;
    logic [INC_W:0]   nxt;
    logic [SUM_W-1:0] modx;
    // Zero increment wins; a zero modulus runs as a modulus of one
    always_comb begin
        modx = (FRAC_MODULUS == 5'h00) ? SUM_W'(5'h01) : SUM_W'(FRAC_MODULUS);
        sum = SUM_W'(NUMERATOR) + SUM_W'(FRAC_INCREMENT);
        nxt = {1'b0, sum[INC_W-1:0]};
        if (sum >= modx)
            nxt = {1'b1, 4'(sum - modx)};
        if (FRAC_INCREMENT == 4'h0)
            nxt = 5'h00;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    step_value_a: assert property (TERMINAL_COUNT |=> {DIVIDE_N_PLUS_ONE, NUMERATOR} == $past(nxt))
        else $error("accumulator step wrong");
    hold_state_a: assert property (!TERMINAL_COUNT |=> $stable({DIVIDE_N_PLUS_ONE, NUMERATOR}))
        else $error("state moved without terminal count");
    zero_inc_a: assert property (TERMINAL_COUNT && FRAC_INCREMENT == 4'h0 |=> {DIVIDE_N_PLUS_ONE, NUMERATOR} == 5'h00)
        else $error("integer mode moved");
    ripple_width_a: assert property (MAIN_RIPPLE_WIDTH == NUMERATOR)
        else $error("ripple width");
    sum_enable_a: assert property (COMP_SUM_ENABLE == COMP_PULSE_ACTIVE)
        else $error("sum enable");
    comp_start_a: assert property (PUMP_EARLY && !COMP_PULSE_ACTIVE |=> COMP_PULSE_ACTIVE && COMP_PULSE_AMPLITUDE == $past(NUMERATOR))
        else $error("pulse start");
    comp_length_a: assert property ($rose(COMP_PULSE_ACTIVE) |-> COMP_PULSE_ACTIVE[*8] ##1 !COMP_PULSE_ACTIVE)
        else $error("pulse length");
    idle_amp_a: assert property (!COMP_PULSE_ACTIVE |-> COMP_PULSE_AMPLITUDE == 4'h0)
        else $error("idle amplitude");
endmodule : frac_acc_checker
bind fractional_n_accumulator frac_acc_checker i_frac_acc_checker (.CLK(CLK), .RST(RST),
    .TERMINAL_COUNT(TERMINAL_COUNT), .PUMP_EARLY(PUMP_EARLY), .FRAC_INCREMENT(FRAC_INCREMENT),
    .FRAC_MODULUS(FRAC_MODULUS), .DIVIDE_N_PLUS_ONE(DIVIDE_N_PLUS_ONE), .NUMERATOR(NUMERATOR),
    .MAIN_RIPPLE_WIDTH(MAIN_RIPPLE_WIDTH), .COMP_PULSE_ACTIVE(COMP_PULSE_ACTIVE),
    .COMP_PULSE_AMPLITUDE(COMP_PULSE_AMPLITUDE), .COMP_SUM_ENABLE(COMP_SUM_ENABLE));
`default_nettype wire

// *** frac_divider_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module frac_divider_model #(
    parameter int N_BASE = 12
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic fast,
    input  wire logic plus_one,
    output logic      tc,
    output logic      early
);
    logic [3:0] cnt_reg;
    // Idle counter is cleared and held at zero, so no stray terminal count leaks out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            tc      <= 1'b0;
            early   <= 1'b0;
        end else begin
            tc      <= run && (fast || cnt_reg == 4'(N_BASE - 1) + 4'(plus_one));
            cnt_reg <= (!run || cnt_reg >= 4'(N_BASE - 1) + 4'(plus_one)) ? 4'h0 : cnt_reg + 4'h1;
            early   <= run && cnt_reg == 4'h1;
        end
    end
endmodule : frac_divider_model
`default_nettype wire

// *** fractional_n_accumulator_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module fractional_n_accumulator_tb_top
    import frac_pkg::*;
();
    logic             CLK = 1'b0;
    logic             RST = 1'b1;
    logic             run = 1'b0;
    logic             fast = 1'b0;
    logic [INC_W-1:0] inc = 4'h0;
    logic [MOD_W-1:0] modv = 5'h08;
    logic             tc, early, dnp, act, sum_en;
    logic [INC_W-1:0] num, ripple, amp;
    int               n_errors = 0;
    int               n_tests = 0;
    always #4 CLK = ~CLK;
    frac_divider_model i_frac_divider_model (.clk(CLK), .rst(RST), .run(run), .fast(fast),
        .plus_one(dnp), .tc(tc), .early(early));
    fractional_n_accumulator i_fractional_n_accumulator (.CLK(CLK), .RST(RST),
        .TERMINAL_COUNT(tc), .PUMP_EARLY(early), .FRAC_INCREMENT(inc), .FRAC_MODULUS(modv),
        .DIVIDE_N_PLUS_ONE(dnp), .NUMERATOR(num), .MAIN_RIPPLE_WIDTH(ripple),
        .COMP_PULSE_ACTIVE(act), .COMP_PULSE_AMPLITUDE(amp), .COMP_SUM_ENABLE(sum_en));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic wait_for(input bit pick_early);
        for (int k = 0; k < 40 && (pick_early ? early : tc) !== 1'b1; k++) begin
            @(posedge CLK);
            #1;
        end
        if ((pick_early ? early : tc) !== 1'b1) begin
            n_errors++;
            $display("[ERR] %s expected 1 seen 0", pick_early ? "early" : "tc");
            report_and_stop();
        end
    endtask : wait_for
    task automatic run_frac(input logic [3:0] i, input logic [4:0] m, input int steps);
        logic [5:0] s;
        logic [3:0] exp_num;
        logic       ovf;
        logic [4:0] me;
        RST = 1'b1;
        repeat (6) @(posedge CLK);
        #1;
        RST = 1'b0;
        inc = i;
        modv = m;
        run = 1'b1;
        exp_num = 4'h0;
        me = (m == 5'h00) ? 5'h01 : m;
        check("after reset", 8'h00, {num, amp});
        for (int k = 0; k < steps; k++) begin
            wait_for(1'b0);
            s = {2'h0, exp_num} + {2'h0, i};
            ovf = (i != 4'h0) && (s >= {1'b0, me});
            exp_num = ovf ? 4'(s - {1'b0, me}) : s[3:0];
            @(posedge CLK);
            #1;
            check("numerator", {4'h0, exp_num}, {4'h0, num});
            check("ripple_width", {4'h0, exp_num}, {4'h0, ripple});
            check("n_plus_one", {7'h0, ovf}, {7'h0, dnp});
        end
    endtask : run_frac
    task automatic comp_pulse();
        int n;
        run_frac(4'h3, 5'h08, 1);
        wait_for(1'b1);
        @(posedge CLK);
        #1;
        check("comp_amp", 8'h03, {4'h0, amp});
        check("comp_active", 8'h01, {7'h0, act});
        check("comp_sum", 8'h01, {7'h0, sum_en});
        for (n = 0; n < 20 && act === 1'b1; n++) begin
            @(posedge CLK);
            #1;
        end
        check("comp_len", 8'(COMP_LEN), 8'(n));
        check("comp_idle", 8'h00, {4'h0, amp});
        check("comp_sum_idle", 8'h00, {7'h0, sum_en});
    endtask : comp_pulse
    initial begin
        run_frac(4'h3, 5'h08, 9);
        run_frac(4'h6, 5'h08, 5);
        run_frac(4'h0, 5'h05, 3);
        run_frac(4'h1, 5'h00, 3);
        fast = 1'b1;
        run_frac(4'hF, 5'h10, 6);
        fast = 1'b0;
        comp_pulse();
        report_and_stop();
    end
endmodule : fractional_n_accumulator_tb_top
`default_nettype wire
